/* File: pkg/link_pkg.sv */
// Constants, types and helpers shared by the packet responder
package link_pkg;

  localparam logic [7:0]  START_MARKER   = 8'h16;
  localparam logic [15:0] MAX_DATA_LEN   = 16'h01FD;
  localparam logic [7:0]  RC_GOOD        = 8'h00;
  localparam logic [7:0]  RC_BAD_PARAM   = 8'hFF;
  localparam logic [7:0]  RC_BAD_OPCODE  = 8'hFE;
  localparam logic [7:0]  RC_BAD_CSUM    = 8'hFD;
  localparam logic [7:0]  RC_LOCAL       = 8'hFC;
  localparam logic [7:0]  RC_AUTO        = 8'hFB;
  localparam logic [7:0]  RC_BAD_DEST    = 8'hFA;
  localparam logic [7:0]  RC_UNABLE      = 8'hF9;
  localparam logic [7:0]  RC_TOO_LONG    = 8'hF8;

  // Reply frame byte positions; the reply carries no data bytes
  localparam logic [3:0]  IDX_MARKER     = 4'h0;
  localparam logic [3:0]  IDX_LEN_HI     = 4'h1;
  localparam logic [3:0]  IDX_LEN_LO     = 4'h2;
  localparam logic [3:0]  IDX_SRC        = 4'h3;
  localparam logic [3:0]  IDX_DST        = 4'h4;
  localparam logic [3:0]  IDX_FSN        = 4'h5;
  localparam logic [3:0]  IDX_OP_HI      = 4'h6;
  localparam logic [3:0]  IDX_OP_LO      = 4'h7;
  localparam logic [3:0]  IDX_CSUM       = 4'h8;

  localparam int          CLK_HZ         = 25000000;
  localparam int          GAP_TIME_MS    = 200;
  // Longest gap, rounded down to whole cycles
  localparam int          GAP_CYCLES     = (CLK_HZ / 1000) * GAP_TIME_MS;

  typedef enum logic [11:0] {
    ST_HUNT   = 12'h001,
    ST_LEN_HI = 12'h002,
    ST_LEN_LO = 12'h004,
    ST_SRC    = 12'h008,
    ST_DST    = 12'h010,
    ST_FSN    = 12'h020,
    ST_OP_HI  = 12'h040,
    ST_OP_LO  = 12'h080,
    ST_DATA   = 12'h100,
    ST_CSUM   = 12'h200,
    ST_EXEC   = 12'h400,
    ST_REPLY  = 12'h800
  } rx_state_e;

  typedef struct packed {
    logic [15:0] len;
    logic [7:0]  src;
    logic [7:0]  dst;
    logic [7:0]  fsn;
    logic [15:0] op;
  } hdr_s;

  typedef struct packed {
    logic [7:0] dst;
    logic [7:0] fsn;
    logic [7:0] code;
  } reply_s;

  typedef struct packed {
    logic       have;
    logic [7:0] src;
    logic [7:0] fsn;
    logic [7:0] code;
  } last_s;

  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    return a + b;
  endfunction

endpackage

/* File: hdl/gap_timer.sv */
// Inter-character gap timer for frame reception
`timescale 1ns/1ps
`default_nettype none
module gap_timer
  import link_pkg::*;
#(
  parameter int LIMIT = GAP_CYCLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic run,
  input  wire logic kick,
  output logic      expired
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  assign expired = run && !kick && (count == LAST);

  always_comb begin
    next_count = count;
    if (!run || kick || expired) begin
      next_count = '0;
    end else begin
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Each quiet cycle inside a frame, except the one that expires, must move the count one step towards the limit
  a_gap_bound: assert property (@(posedge clk) disable iff (sys_rst)
    run && !kick && !expired |=> count == $past(count) + W'(1))
    else $error("gap timer did not advance on a quiet cycle");
endmodule
`default_nettype wire

/* File: hdl/reply_tx.sv */
// Serialiser for zero-length reply frames
`timescale 1ns/1ps
`default_nettype none
module reply_tx
  import link_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire reply_s     rep,
  input  wire logic [7:0] own_addr,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            busy
);
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic       next_valid;
  logic [7:0] next_data;
  reply_s     rep_q;
  reply_s     next_rep;

  function automatic logic [7:0] reply_byte(input logic [3:0] i, input reply_s r, input logic [7:0] a);
    unique case (i)
      IDX_MARKER: return START_MARKER;
      IDX_SRC:    return a;
      IDX_DST:    return r.dst;
      IDX_FSN:    return r.fsn;
      IDX_OP_LO:  return r.code;
      IDX_CSUM:   return csum_add(csum_add(a, r.dst), csum_add(r.fsn, r.code));
      default:    return 8'h00;
    endcase
  endfunction

  assign busy = tx_valid;

  always_comb begin
    next_idx   = idx;
    next_valid = tx_valid;
    next_data  = tx_data;
    next_rep   = rep_q;
    if (start && !tx_valid) begin
      next_rep   = rep;
      next_idx   = IDX_MARKER;
      next_valid = 1'b1;
      next_data  = reply_byte(IDX_MARKER, rep, own_addr);
    end else if (tx_valid && tx_ready) begin
      next_idx  = idx + 4'h1;
      next_data = reply_byte(idx + 4'h1, rep_q, own_addr);
      if (idx == IDX_CSUM) begin
        next_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx      <= IDX_MARKER;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      rep_q    <= '0;
    end else begin
      idx      <= next_idx;
      tx_valid <= next_valid;
      tx_data  <= next_data;
      rep_q    <= next_rep;
    end
  end

  a_reply_marker: assert property (@(posedge clk) disable iff (sys_rst)
    start && !tx_valid |=> tx_valid && tx_data == START_MARKER && idx == IDX_MARKER)
    else $error("reply does not open with the start marker");
  a_reply_swap: assert property (@(posedge clk) disable iff (sys_rst)
    tx_valid && idx == IDX_DST |-> tx_data == rep_q.dst)
    else $error("reply destination is not the requester");
  a_reply_code: assert property (@(posedge clk) disable iff (sys_rst)
    tx_valid && idx == IDX_OP_LO |-> tx_data == rep_q.code)
    else $error("reply operation code byte is wrong");
endmodule
`default_nettype wire

/* File: hdl/packet_responder.sv */
// Link-level packet receiver and responder for a multi-drop control bus
// Function
// - Valid frame: reply with swapped addresses
// - Good 0, bad parameter 255, opcode 254, checksum 253
// - Local control refuses 252, automatic 251
// - Bad destination 250, unable 249, too long 248
// - Extra data bytes pass without error
// - Checksum covers all bytes but marker, checksum
// - Checksum mismatch: no execution, negative reply
// - Repeated tag: acknowledge again, never re-execute
// - Frames start with marker 0x16
// - Length, source, destination, tag, opcode order
// - Operation code is two bytes
// - Counted data, then modulo-256 checksum byte
// - Overlong character gap abandons the frame
// - Bad checksum discards frame, hunt again
// - Sequence tag is eight bits, wrapping
// - Data length limited to 0..509
`timescale 1ns/1ps
`default_nettype none
module packet_responder
  import link_pkg::*;
#(
  parameter int GAP_LIMIT = GAP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] dev_addr,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready,
  input  wire logic       local_mode,
  input  wire logic       auto_mode,
  output logic            data_valid,
  output logic [7:0]      data_byte,
  output logic [8:0]      data_index,
  output logic            exec_valid,
  output hdr_s            exec_hdr,
  input  wire logic       exec_done,
  input  wire logic [7:0] exec_code
);
  rx_state_e  state;
  rx_state_e  next_state;
  hdr_s       hdr;
  hdr_s       next_hdr;
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic [7:0] sum;
  logic [7:0] next_sum;
  logic       too_long;
  logic       next_too_long;
  last_s      last;
  last_s      next_last;
  reply_s     rep;
  reply_s     next_rep;
  logic       tx_start;
  logic       next_tx_start;
  logic       next_data_valid;
  logic [7:0] next_data_byte;
  logic [8:0] next_data_index;
  logic       tx_busy;
  logic       gap_expired;
  logic       receiving;
  logic       dup;
  logic       csum_ok;

  // Binary payload may hold the marker value, so only the hunt state looks for it
  assign receiving  = !(state inside {ST_HUNT, ST_EXEC, ST_REPLY});
  assign csum_ok    = (rx_data == sum);
  assign dup        = last.have && last.src == hdr.src && last.fsn == hdr.fsn;
  assign exec_valid = (state == ST_EXEC);
  assign exec_hdr   = hdr;

  gap_timer #(
    .LIMIT(GAP_LIMIT)
  ) u_gap (
    .clk    (clk),
    .sys_rst(sys_rst),
    .run    (receiving),
    .kick   (rx_valid),
    .expired(gap_expired)
  );

  reply_tx u_tx (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (tx_start),
    .rep     (rep),
    .own_addr(dev_addr),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data (tx_data),
    .busy    (tx_busy)
  );

  always_comb begin
    next_state      = state;
    next_hdr        = hdr;
    next_cnt        = cnt;
    next_sum        = sum;
    next_too_long   = too_long;
    next_last       = last;
    next_rep        = rep;
    next_tx_start   = 1'b0;
    next_data_valid = 1'b0;
    next_data_byte  = data_byte;
    next_data_index = data_index;
    if (rx_valid && receiving && state != ST_CSUM) begin
      next_sum = csum_add(sum, rx_data);
    end
    unique case (state)
      ST_HUNT: begin
        if (rx_valid && rx_data == START_MARKER) begin
          next_state = ST_LEN_HI;
          next_sum   = 8'h00;
        end
      end
      ST_LEN_HI: begin
        if (rx_valid) begin
          next_hdr.len[15:8] = rx_data;
          next_state         = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        if (rx_valid) begin
          next_hdr.len[7:0] = rx_data;
          next_too_long     = ({hdr.len[15:8], rx_data} > MAX_DATA_LEN);
          next_state        = ST_SRC;
        end
      end
      ST_SRC: begin
        if (rx_valid) begin
          next_hdr.src = rx_data;
          next_state   = ST_DST;
        end
      end
      ST_DST: begin
        if (rx_valid) begin
          next_hdr.dst = rx_data;
          next_state   = (rx_data == dev_addr) ? ST_FSN : ST_HUNT;
        end
      end
      ST_FSN: begin
        if (rx_valid) begin
          next_hdr.fsn = rx_data;
          next_rep.dst = hdr.src;
          next_rep.fsn = rx_data;
          if (too_long) begin
            // Remaining length is untrustworthy, so answer now and hunt again
            next_rep.code = RC_TOO_LONG;
            next_tx_start = 1'b1;
            next_state    = ST_REPLY;
          end else begin
            next_state = ST_OP_HI;
          end
        end
      end
      ST_OP_HI: begin
        if (rx_valid) begin
          next_hdr.op[15:8] = rx_data;
          next_state        = ST_OP_LO;
        end
      end
      ST_OP_LO: begin
        if (rx_valid) begin
          next_hdr.op[7:0] = rx_data;
          next_cnt         = 9'h000;
          next_state       = (hdr.len == 16'h0000) ? ST_CSUM : ST_DATA;
        end
      end
      ST_DATA: begin
        if (rx_valid) begin
          // Every counted byte goes to the user; unknown trailing ones are its to drop
          next_data_valid = 1'b1;
          next_data_byte  = rx_data;
          next_data_index = cnt;
          next_cnt        = cnt + 9'h001;
          if (cnt + 9'h001 == hdr.len[8:0]) begin
            next_state = ST_CSUM;
          end
        end
      end
      ST_CSUM: begin
        if (rx_valid) begin
          next_state = ST_REPLY;
          next_tx_start = 1'b1;
          if (!csum_ok) begin
            next_rep.code = RC_BAD_CSUM;
          end else if (dup) begin
            next_rep.code = last.code;
          end else if (local_mode) begin
            next_rep.code  = RC_LOCAL;
            next_last      = '{have: 1'b1, src: hdr.src, fsn: hdr.fsn, code: RC_LOCAL};
          end else if (auto_mode) begin
            next_rep.code  = RC_AUTO;
            next_last      = '{have: 1'b1, src: hdr.src, fsn: hdr.fsn, code: RC_AUTO};
          end else begin
            next_tx_start = 1'b0;
            next_state    = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (exec_done) begin
          next_rep.code = exec_code;
          next_last     = '{have: 1'b1, src: hdr.src, fsn: hdr.fsn, code: exec_code};
          next_tx_start = 1'b1;
          next_state    = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (!tx_start && !tx_busy) begin
          next_state = ST_HUNT;
        end
      end
    endcase
    if (gap_expired) begin
      next_state = ST_HUNT;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= ST_HUNT;
      hdr        <= '0;
      cnt        <= 9'h000;
      sum        <= 8'h00;
      too_long   <= 1'b0;
      last       <= '0;
      rep        <= '0;
      tx_start   <= 1'b0;
      data_valid <= 1'b0;
      data_byte  <= 8'h00;
      data_index <= 9'h000;
    end else begin
      state      <= next_state;
      hdr        <= next_hdr;
      cnt        <= next_cnt;
      sum        <= next_sum;
      too_long   <= next_too_long;
      last       <= next_last;
      rep        <= next_rep;
      tx_start   <= next_tx_start;
      data_valid <= next_data_valid;
      data_byte  <= next_data_byte;
      data_index <= next_data_index;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_csum_bad;
    state == ST_CSUM && rx_valid && !csum_ok && !gap_expired;
  endsequence
  sequence s_nak_out;
    state == ST_REPLY && tx_start && rep.code == RC_BAD_CSUM ##1 tx_valid;
  endsequence

  a_bad_csum: assert property (s_csum_bad |=> s_nak_out)
    else $error("checksum error did not produce a negative reply");
  a_bad_discard: assert property (s_csum_bad |-> ##1 !exec_valid [*2])
    else $error("frame with bad checksum was executed");
  a_dup_noexec: assert property (state == ST_CSUM && rx_valid && csum_ok && dup |=>
    state == ST_REPLY && rep.code == last.code)
    else $error("repeated frame was executed again");
  a_gap_abort: assert property (gap_expired |=> state == ST_HUNT)
    else $error("frame survived an overlong character gap");
  a_dst_ignore: assert property (state == ST_DST && rx_valid && rx_data != dev_addr && !gap_expired
    |=> state == ST_HUNT && !tx_start)
    else $error("frame for another node was not ignored");
  a_too_long: assert property (state == ST_FSN && rx_valid && too_long && !gap_expired
    |=> tx_start && rep.code == RC_TOO_LONG)
    else $error("overlong frame not answered with its code");
  a_local_refuse: assert property (state == ST_CSUM && rx_valid && csum_ok && !dup && local_mode
    && !gap_expired |=> rep.code == RC_LOCAL && state == ST_REPLY)
    else $error("local control did not refuse the command");
  a_reply_addr: assert property (tx_start |-> rep.dst == hdr.src && rep.fsn == hdr.fsn)
    else $error("reply not addressed back to the sender");

  sequence s_marker_seen;
    state == ST_HUNT && rx_valid && rx_data == START_MARKER;
  endsequence
  sequence s_frame_open;
    state == ST_LEN_HI && sum == 8'h00;
  endsequence

  a_marker_open: assert property (s_marker_seen |=> s_frame_open)
    else $error("start marker did not open a fresh frame");
  a_hunt_drop: assert property (state == ST_HUNT && rx_valid && rx_data != START_MARKER
    |=> state == ST_HUNT)
    else $error("stray byte left the hunt state");
  a_data_out: assert property (state == ST_DATA && rx_valid |=> data_valid && data_byte == $past(rx_data)
    && data_index == $past(cnt))
    else $error("data byte not handed to the user");
  a_data_end: assert property (state == ST_DATA && rx_valid && cnt + 9'h001 == hdr.len[8:0]
    |=> state == ST_CSUM)
    else $error("data field length not honoured");
  a_auto_refuse: assert property (state == ST_CSUM && rx_valid && csum_ok && !dup && !local_mode && auto_mode
    |=> rep.code == RC_AUTO && state == ST_REPLY)
    else $error("automatic operation did not refuse the command");
  a_exec_offer: assert property (state == ST_CSUM && rx_valid && csum_ok && !dup && !local_mode && !auto_mode
    |=> exec_valid && exec_hdr == $past(hdr))
    else $error("good new frame was not offered for execution");
endmodule
`default_nettype wire

/* File: bench/host_model.sv */
// Host model: sends command frames and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module host_model
  import link_pkg::*;
(
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       slow;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  // Slow mode toggles tx_ready each cycle, so reply bytes are taken only every other cycle
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    tx_ready <= #1 slow ? ~tx_ready : 1'b1;
  end

  // One byte per strobe; idle data shows the inverse so stale values never match
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_data  = b;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_data  = ~b;
  endtask

  // Byte gap stays at one cycle, far inside the limit
  task automatic send(input logic [15:0] len, input logic [7:0] src, dst, fsn,
                      input logic [15:0] op, input int nd, input logic [7:0] bad, input int stop);
    logic [7:0] f[$];
    logic [7:0] s;
    f = {len[15:8], len[7:0], src, dst, fsn, op[15:8], op[7:0]};
    for (int i = 0; i < nd; i++) f.push_back(8'(8'hA0 + i));
    s = 8'h00;
    foreach (f[i]) s = s + f[i];
    f.push_back(s ^ bad);
    put(START_MARKER);
    foreach (f[i]) if (i < stop) put(f[i]);
  endtask
endmodule
`default_nettype wire

/* File: bench/test_packet_responder.sv */
// Self-checking bench for the packet responder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_packet_responder;
  import link_pkg::*;
  localparam int         GAP  = 20;
  localparam logic [7:0] ADDR = 8'h5A;
  localparam logic [7:0] HOST = 8'h21;
  logic clk, sys_rst, rx_valid, tx_valid, tx_ready, local_mode, auto_mode;
  logic data_valid, exec_valid, exec_done;
  logic [7:0] rx_data, tx_data, data_byte, exec_code;
  logic [8:0] data_index;
  hdr_s       exec_hdr, last_hdr;
  logic [16:0] dq[$];
  int mismatches = 0;
  int n_compared = 0;
  int n_exec = 0;
  int cycles = 0;

  packet_responder #(.GAP_LIMIT(GAP)) packet_responder_i (
    .clk(clk), .sys_rst(sys_rst), .dev_addr(ADDR), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .local_mode(local_mode),
    .auto_mode(auto_mode), .data_valid(data_valid), .data_byte(data_byte),
    .data_index(data_index), .exec_valid(exec_valid), .exec_hdr(exec_hdr),
    .exec_done(exec_done), .exec_code(exec_code));
  host_model host_model_i (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // User side finishes each command one cycle after it is offered
  always @(posedge clk) begin
    if (data_valid === 1'b1) dq.push_back({data_index, data_byte});
    if (exec_valid === 1'b1 && exec_done === 1'b0) begin
      n_exec++;
      last_hdr = exec_hdr;
      exec_done <= #1 1'b1;
    end else exec_done <= #1 1'b0;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic xfer(input logic [15:0] len, input logic [7:0] dst, fsn, input int nd,
                      input logic [7:0] bad, input int stop, input logic [7:0] code, input bit ex, rep);
    logic [7:0] e[9];
    int e0;
    int t;
    repeat (3) @(posedge clk);
    #1;
    e0 = n_exec;
    dq.delete();
    host_model_i.got.delete();
    host_model_i.send(len, HOST, dst, fsn, 16'h2284, nd, bad, stop);
    t = 0;
    while (host_model_i.got.size() < (rep ? 9 : 1) && t < 300) begin
      @(posedge clk);
      t++;
    end
    #1;
    e = '{START_MARKER, 8'h00, 8'h00, ADDR, HOST, fsn, 8'h00, code, 8'(ADDR + HOST + fsn + code)};
    if (rep) for (int i = 0; i < 9; i++) `CHK("reply byte", e[i], host_model_i.got[i])
    else `CHK("reply count", 0, host_model_i.got.size())
    `CHK("exec count", int'(ex), n_exec - e0)
    if (ex) `CHK("exec header", hdr_s'{len, HOST, dst, fsn, 16'h2284}, last_hdr)
    `CHK("data count", nd, dq.size())
    if (nd > 0) `CHK("last data", {9'(nd - 1), 8'(8'hA0 + nd - 1)}, dq[nd - 1])
  endtask

  task automatic t_good_dup();
    host_model_i.slow = 1'b1;
    exec_code = 8'h00;
    xfer(16'h0003, ADDR, 8'h01, 3, 8'h00, 99, 8'h00, 1, 1);
    host_model_i.slow = 1'b0;
    exec_code = 8'hFF;
    xfer(16'h0003, ADDR, 8'h01, 3, 8'h00, 99, 8'h00, 0, 1);
  endtask

  task automatic t_bad_csum();
    exec_code = 8'h00;
    xfer(16'h0002, ADDR, 8'h02, 2, 8'h01, 99, RC_BAD_CSUM, 0, 1);
    xfer(16'h0002, ADDR, 8'h02, 2, 8'h00, 99, 8'h00, 1, 1);
  endtask

  task automatic t_user_codes();
    logic [7:0] c[4];
    c = '{RC_BAD_PARAM, RC_BAD_OPCODE, RC_BAD_DEST, RC_UNABLE};
    for (int i = 0; i < 4; i++) begin
      exec_code = c[i];
      xfer(16'h0000, ADDR, 8'(8'h03 + i), 0, 8'h00, 99, c[i], 1, 1);
    end
  endtask

  task automatic t_modes();
    exec_code = 8'h00;
    local_mode = 1'b1;
    xfer(16'h0001, ADDR, 8'h07, 1, 8'h00, 99, RC_LOCAL, 0, 1);
    auto_mode = 1'b1;
    xfer(16'h0001, ADDR, 8'h08, 1, 8'h00, 99, RC_LOCAL, 0, 1);
    local_mode = 1'b0;
    xfer(16'h0001, ADDR, 8'h09, 1, 8'h00, 99, RC_AUTO, 0, 1);
    auto_mode = 1'b0;
  endtask

  task automatic t_length();
    xfer(16'h01FE, ADDR, 8'h0A, 0, 8'h00, 5, RC_TOO_LONG, 0, 1);
    xfer(MAX_DATA_LEN, ADDR, 8'h0B, 509, 8'h00, 999, 8'h00, 1, 1);
  endtask

  task automatic t_dest_gap_wrap();
    xfer(16'h0000, 8'h5B, 8'h0C, 0, 8'h00, 99, 8'h00, 0, 0);
    host_model_i.send(16'h0000, HOST, ADDR, 8'h0D, 16'h2284, 0, 8'h00, 3);
    repeat (2 * GAP) @(posedge clk);
    xfer(16'h0000, ADDR, 8'h0D, 0, 8'h00, 99, 8'h00, 1, 1);
    xfer(16'h0000, ADDR, 8'hFF, 0, 8'h00, 99, 8'h00, 1, 1);
    xfer(16'h0000, ADDR, 8'h00, 0, 8'h00, 99, 8'h00, 1, 1);
  endtask

  initial begin
    sys_rst    = 1'b1;
    local_mode = 1'b0;
    auto_mode  = 1'b0;
    exec_done  = 1'b0;
    exec_code  = 8'h00;
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_good_dup();
    t_bad_csum();
    t_user_codes();
    t_modes();
    t_length();
    t_dest_gap_wrap();
    give_verdict();
  end
endmodule
`default_nettype wire
